/* File: shared/psc_defs.svh */
// Strap loader constants: defaults, timing counts
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_MODE_ENHANCED     1'b1
`define PSC_AUTONEG_ON        1'b0
`define PSC_ODDNIB_ON         1'b1
`define PSC_PINFN_LINK_LED_B        1'b1
`define PSC_FLD_ON            1'b1
`define PSC_SED_OFF           1'b1
`define PSC_AUTOMDIX_ON       1'b0
`define PSC_FORCE_MDIX        1'b0
`define PSC_DEF_ADDR          3'h0
`define PSC_SETTLE_NS         100
`define PSC_CLK_NS            20
`define PSC_SETTLE_CYC        ((`PSC_SETTLE_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_CNT_W             4
`endif

/* File: shared/psc_pkg.sv */
// Types shared by the strap loader
`default_nettype none
package psc_pkg;
  typedef struct packed {
    logic       mode_select_strap;
    logic       autoNegStrap;
    logic       oddNibbleStrap;
    logic [2:0] phyAddrStrap;
    logic       rmiiSlaveStrap;
    logic       pinFuncStrap;
    logic       fldStrap;
    logic       energyStrap;
    logic       mdixAutoStrap;
    logic       mdixForceStrap;
    logic       ledPolStrap;
  } psc_straps_t;

  typedef struct packed {
    logic       enhancedMode;
    logic       autoNegEn;
    logic       force100;
    logic       oddNibbleEn;
    logic       macIsMii;
    logic       rmiiSlave;
    logic       macAltSel;
    logic       fldRxErrOnly;
    logic       fldAllButMlt3;
    logic       repeaterEn;
    logic       energyDetectEn;
    logic       autoMdixEn;
    logic       forceMdi;
    logic [2:0] phyAddr;
    logic       ledActiveLow;
    logic       ledAutoPolEn;
  } psc_cfg_t;

  typedef enum logic [1:0] {
    PSC_ST_RESET  = 2'b00,
    PSC_ST_SETTLE = 2'b01,
    PSC_ST_RUN    = 2'b10
  } psc_state_t;
endpackage
`default_nettype wire

/* File: rtl/psc_strap_loader.sv */
// Power-on strap sampling and configuration decode for a 10/100 PHY
`include "psc_defs.svh"
`default_nettype none
module psc_strap_loader
  import psc_pkg::*;
#(
  // Counter is PSC_CNT_W bits wide: keep SETTLE_CYC below 16
  parameter int SETTLE_CYC = `PSC_SETTLE_CYC
) (
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     porDone,
  input  wire psc_straps_t strapPins,
  input  wire logic     link100Fd,
  input  wire logic     rxNibbleOdd,
  output var  psc_cfg_t cfgOut,
  output var  logic     cfgValid,
  output var  logic     pinIsLed1,
  output var  logic     linkLedOut,
  output var  logic     oddNibbleErr
);

  psc_straps_t         sync1_reg;
  psc_straps_t         sync2_reg;
  psc_straps_t         latched_reg;
  psc_state_t          state_reg;
  logic [`PSC_CNT_W-1:0] cnt_reg;
  logic                porSync1_reg;
  logic                porSync2_reg;
  logic                porSeen_reg;
  logic                pinFnDone_reg;
  logic                link1_reg;
  logic                link2_reg;
  logic                odd1_reg;
  logic                odd2_reg;
  psc_cfg_t            cfg_next;

  // Pins are asynchronous to the core clock
  // Reset to zero; pull defaults are the pins' job, not the core's
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= strapPins;
      sync2_reg <= sync1_reg;
    end
  end

  // Power-on sync has no rst_n: a hardware reset must not look like a
  // power-on to the pin-function latch
  always_ff @(posedge clock) begin
    porSync1_reg <= porDone;
    porSync2_reg <= porSync1_reg;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link1_reg <= 1'b0;
      link2_reg <= 1'b0;
    end else begin
      link1_reg <= link100Fd;
      link2_reg <= link1_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      odd1_reg <= 1'b0;
      odd2_reg <= 1'b0;
    end else begin
      odd1_reg <= rxNibbleOdd;
      odd2_reg <= odd1_reg;
    end
  end

  // Last settle edge: synchronisers hold the pins by now
  function automatic logic settle_done(
    input psc_state_t            st,
    input logic [`PSC_CNT_W-1:0] cnt
  );
    return st == PSC_ST_SETTLE && cnt >= `PSC_CNT_W'(SETTLE_CYC);
  endfunction

  // Wait for synchronisers to fill before sampling
  // Configuration appears SETTLE_CYC+3 edges after rst_n rises;
  // straps must be steady over that whole span.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PSC_ST_RESET;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        PSC_ST_RESET: begin
          state_reg <= PSC_ST_SETTLE;
          cnt_reg   <= '0;
        end
        PSC_ST_SETTLE: begin
          if (settle_done(state_reg, cnt_reg)) begin
            state_reg <= PSC_ST_RUN;
          end else begin
            cnt_reg <= cnt_reg + `PSC_CNT_W'(1);
          end
        end
        PSC_ST_RUN: begin
          state_reg <= PSC_ST_RUN;
        end
        // Stray code from an upset: restart the sample
        default: begin
          state_reg <= PSC_ST_RESET;
        end
      endcase
    end
  end

  // Capture once per reset, then hold
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latched_reg <= '0;
    end else if (settle_done(state_reg, cnt_reg)) begin
      latched_reg <= sync2_reg;
    end
  end

  // Pin function survives hardware reset: only a power-on edge loads it.
  // Flops have no async reset so rst_n cannot disturb them.
  always_ff @(posedge clock) begin
    if (!porSync2_reg) begin
      porSeen_reg   <= 1'b0;
      pinFnDone_reg <= 1'b0;
    end else if (!pinFnDone_reg) begin
      porSeen_reg   <= 1'b1;
      pinFnDone_reg <= porSeen_reg;
    end
  end

  // Loads on the first two edges after power-on, then holds
  always_ff @(posedge clock) begin
    if (!porSync2_reg) begin
      pinIsLed1 <= 1'b0;
    end else if (!pinFnDone_reg) begin
      pinIsLed1 <= (sync2_reg.pinFuncStrap == `PSC_PINFN_LINK_LED_B);
    end
  end

  // Strap tests are functions: several outputs hinge on the same pin
  function automatic logic mode_is_enhanced(
    input psc_straps_t s
  );
    return s.mode_select_strap == `PSC_MODE_ENHANCED;
  endfunction

  // Strap 0 means auto-negotiation runs
  function automatic logic autoneg_on(
    input psc_straps_t s
  );
    return s.autoNegStrap == `PSC_AUTONEG_ON;
  endfunction

  // Odd-nibble strap also decides the MAC interface
  function automatic logic odd_on(
    input psc_straps_t s
  );
    return s.oddNibbleStrap == `PSC_ODDNIB_ON;
  endfunction

  // Fast link drop requested
  function automatic logic fld_on(
    input psc_straps_t s
  );
    return s.fldStrap == `PSC_FLD_ON;
  endfunction

  // Strap 1 switches the signal energy detector off
  function automatic logic energy_off(
    input psc_straps_t s
  );
    return s.energyStrap == `PSC_SED_OFF;
  endfunction

  function automatic logic mdix_auto_on(
    input psc_straps_t s
  );
    return s.mdixAutoStrap == `PSC_AUTOMDIX_ON;
  endfunction

  // Forced pair order only counts with auto crossover off; 0 is MDIX
  function automatic logic mdix_force_mdi(
    input psc_straps_t s
  );
    return !mdix_auto_on(s) && (s.mdixForceStrap != `PSC_FORCE_MDIX);
  endfunction

  // Decode reads only the frozen latch, never the live pins
  always_comb begin
    psc_straps_t s;
    s = latched_reg;
    cfg_next = '0;

    cfg_next.enhancedMode = mode_is_enhanced(s);
    cfg_next.autoNegEn    = autoneg_on(s);
    cfg_next.force100     = !autoneg_on(s);

    // Odd-nibble strap forces MII; otherwise reduced interface
    cfg_next.oddNibbleEn  = odd_on(s);
    cfg_next.macIsMii     = odd_on(s);
    // Master/slave only matters in reduced-interface mode
    cfg_next.rmiiSlave    = odd_on(s) ? 1'b0 : s.rmiiSlaveStrap;

    // Link drop sources depend on the odd-nibble mode
    cfg_next.fldRxErrOnly  = fld_on(s) && !odd_on(s);
    cfg_next.fldAllButMlt3 = fld_on(s) && odd_on(s);
    // Same strap reused for repeater in reduced interface
    cfg_next.repeaterEn    = fld_on(s) && !odd_on(s);

    // With odd-nibble on the strap picks the MAC, detector stays on
    cfg_next.macAltSel      = odd_on(s) && s.energyStrap;
    cfg_next.energyDetectEn = odd_on(s) || !energy_off(s);

    cfg_next.autoMdixEn   = mdix_auto_on(s);
    cfg_next.forceMdi     = mdix_force_mdi(s);
    cfg_next.phyAddr      = s.phyAddrStrap;

    // Pull-up network means LED is driven active low in basic mode; enhanced mode follows ledPolStrap
    cfg_next.ledAutoPolEn = mode_is_enhanced(s);
    cfg_next.ledActiveLow = mode_is_enhanced(s) ? s.ledPolStrap : 1'b1;
  end

  // Outputs stay at defaults until sampling is done
  // Reloaded each RUN cycle from a frozen latch, so it never moves
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgOut <= '0;
    end else if (state_reg == PSC_ST_RUN) begin
      cfgOut <= cfg_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgValid <= 1'b0;
    end else if (state_reg == PSC_ST_RUN) begin
      cfgValid <= 1'b1;
    end
  end

  // Link indication with strap-selected polarity
  // Held at 1 before config: dark for an active-low LED, shows link when ledActiveLow is clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      linkLedOut <= 1'b1;
    end else begin
      linkLedOut <= cfgValid ? (link2_reg ^ cfgOut.ledActiveLow) : 1'b1;
    end
  end

  // Incomplete nibble flags a receive error when detection is on
  // Gated by cfgValid so a half-loaded config raises no error
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oddNibbleErr <= 1'b0;
    end else begin
      oddNibbleErr <= cfgValid && cfgOut.oddNibbleEn && odd2_reg;
    end
  end

endmodule // psc_strap_loader
`default_nettype wire

/* File: test/psc_loader_monitor.sv */
// Port assertions for the strap loader
`default_nettype none
module psc_loader_monitor
  import psc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire psc_cfg_t    cfgOut,
  input wire logic        cfgValid,
  input wire logic        link100Fd,
  input wire logic        rxNibbleOdd,
  input wire logic        linkLedOut,
  input wire logic        oddNibbleErr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rel; $rose(rst_n); endsequence
  sequence s_idle; !cfgValid [*3]; endsequence
  a_valid_late: assert property (s_rel |-> s_idle ##[1:6] cfgValid)
    else $error("config valid out of window");
  a_cfg_zero: assert property (!cfgValid |-> cfgOut == '0)
    else $error("config not clear before valid");
  a_cfg_hold: assert property (cfgValid |=> cfgValid && $stable(cfgOut))
    else $error("config moved after sampling");
  a_mii_slave: assert property (cfgOut.macIsMii |->
    cfgOut.oddNibbleEn && !cfgOut.rmiiSlave && cfgOut.energyDetectEn)
    else $error("slave strap honoured in MII");
  a_fld_mode: assert property (!(cfgOut.fldRxErrOnly &&
    cfgOut.fldAllButMlt3) && cfgOut.repeaterEn == cfgOut.fldRxErrOnly)
    else $error("link drop sources inconsistent");
  a_speed_force: assert property (cfgValid |->
    cfgOut.force100 != cfgOut.autoNegEn)
    else $error("speed force wrong");
  a_led_path: assert property (cfgValid && $past(cfgValid, 3) |->
    linkLedOut == ($past(link100Fd, 3) ^ cfgOut.ledActiveLow))
    else $error("link LED wrong");
  a_err_path: assert property (cfgValid && $past(cfgValid, 3) |->
    oddNibbleErr == (cfgOut.oddNibbleEn && $past(rxNibbleOdd, 3)))
    else $error("odd nibble error wrong");
endmodule // psc_loader_monitor
bind psc_strap_loader psc_loader_monitor u_psc_loader_monitor (.clock,
  .rst_n, .cfgOut, .cfgValid, .link100Fd, .rxNibbleOdd, .linkLedOut,
  .oddNibbleErr);
`default_nettype wire

/* File: test/psc_esc_model.sv */
// Far-side controller model: link and nibble status levels
`default_nettype none
module psc_esc_model (
  input  wire logic clock,
  input  wire logic rst_n,
  output var  logic link100Fd,
  output var  logic rxNibbleOdd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pattern_reg;
  // Busy pattern so LED lag is visible
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pattern_reg <= 8'hA5;
    else pattern_reg <= {pattern_reg[6:0], ^(pattern_reg & 8'hB8)};
  end
  assign link100Fd = pattern_reg[7];
  assign rxNibbleOdd = pattern_reg[2] & pattern_reg[0];
endmodule // psc_esc_model
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the strap loader
`default_nettype none
module tb_top;
  import psc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {psc_cfg_t cfg; logic pin;} psc_note_t;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        porDone = 1'b0;
  psc_straps_t strapPins = '0;
  logic        link100Fd, rxNibbleOdd, cfgValid, pinIsLed1;
  logic        linkLedOut, oddNibbleErr, porPin;
  logic        seenValid = 1'b0;
  psc_cfg_t    cfgOut;
  logic [31:0] seed = 32'hFDC6;
  int          nFail = 0;
  int          samplesChecked = 0;
  psc_note_t   notes[$];
  initial begin
    forever #10 clock = ~clock;
  end
  psc_strap_loader #(.SETTLE_CYC(1)) u_psc_strap_loader (.clock, .rst_n,
    .porDone, .strapPins, .link100Fd, .rxNibbleOdd, .cfgOut, .cfgValid,
    .pinIsLed1, .linkLedOut, .oddNibbleErr);
  psc_esc_model u_psc_esc_model (.clock, .rst_n, .link100Fd, .rxNibbleOdd);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic psc_cfg_t decode(input psc_straps_t s);
    psc_cfg_t c;
    c.enhancedMode = s.mode_select_strap;
    c.autoNegEn = !s.autoNegStrap;
    c.force100 = s.autoNegStrap;
    c.oddNibbleEn = s.oddNibbleStrap;
    c.macIsMii = s.oddNibbleStrap;
    c.rmiiSlave = s.rmiiSlaveStrap & !s.oddNibbleStrap;
    c.macAltSel = s.oddNibbleStrap & s.energyStrap;
    c.energyDetectEn = s.oddNibbleStrap | !s.energyStrap;
    c.fldRxErrOnly = s.fldStrap & !s.oddNibbleStrap;
    c.fldAllButMlt3 = s.fldStrap & s.oddNibbleStrap;
    c.repeaterEn = c.fldRxErrOnly;
    c.autoMdixEn = !s.mdixAutoStrap;
    c.forceMdi = s.mdixAutoStrap & s.mdixForceStrap;
    c.phyAddr = s.phyAddrStrap;
    c.ledAutoPolEn = s.mode_select_strap;
    c.ledActiveLow = !s.mode_select_strap | s.ledPolStrap;
    return c;
  endfunction
  task automatic check(input psc_note_t seen, input psc_note_t exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD %0t cfg %h want %h", $time, seen, exp);
    end
  endtask
  task automatic reportAndStop;
    if (nFail == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (cfgValid === 1'b1 && !seenValid && notes.size() > 0)
      check({cfgOut, pinIsLed1}, notes.pop_front());
    seenValid <= (cfgValid === 1'b1);
  end
  initial begin
    repeat (1000) @(posedge clock);
    nFail++;
    reportAndStop();
  end
  initial begin
    psc_straps_t s;
    repeat (20) @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      s = seed[$bits(s)-1:0];
      if (i == 0) begin
        s.mode_select_strap = 1'b1;
        s.oddNibbleStrap = 1'b0;
        s.fldStrap = 1'b1;
        s.energyStrap = 1'b1;
      end
      // Pin function reloads only on a power-on cycle
      if (i % 4 == 0) porPin = s.pinFuncStrap;
      @(posedge clock);
      strapPins <= s;
      rst_n <= 1'b0;
      if (i % 4 == 0) porDone <= 1'b0;
      notes.push_back({decode(s), porPin});
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      porDone <= 1'b1;
      repeat (12) @(posedge clock);
      strapPins <= ~s;
      repeat (4) @(posedge clock);
    end
    if (notes.size() != 0) nFail++;
    reportAndStop();
  end
endmodule // tb_top
`default_nettype wire
